// *** hdl/wkm_msg_rx.sv ***
// Purpose: Receives one wake-up message after its header
// Assumes: Bits arrive from logic on the same clock, one per bit_valid_i
// Notes: Stuff bits are dropped; a run of six ones marks the stop field
`timescale 1ns/1ps
module wkm_msg_rx
   import wkm_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic use_data_i,
   input wire logic use_stop_i,
   input wire logic use_addr_i,
   input wire logic no_stuff_i,
   input wire logic [4:0] payload_length_i,
   input wire logic [ADDR_W-1:0] target_addr_i,
   input wire logic bit_valid_i,
   input wire logic bit_i,
   output logic done_o,
   output logic ok_o,
   output logic err_o,
   output logic [4:0] len_o,
   output logic [31:0] payload_o
);
   logic active_ff, data_ph_ff, last_ff;
   logic [2:0] run_ff;
   logic [7:0] acnt_ff;
   logic [5:0] dcnt_ff;
   logic [ADDR_W-1:0] addr_ff;
   logic [36:0] sh_ff;
   logic done_ff, ok_ff, err_ff;
   logic [4:0] len_ff;
   logic [31:0] pay_ff;

   wire same_w = bit_i == last_ff;
   wire [2:0] nxt_run = same_w ? run_ff + 3'h1 : 3'h1;
   wire stuff_slot_w = !no_stuff_i && run_ff == WKM_STUFF_RUN;
   wire stop_w = use_stop_i && data_ph_ff && bit_i && last_ff
      && run_ff == WKM_STUFF_RUN;
   wire stuff_err_w = stuff_slot_w && same_w && !stop_w;
   wire take_w = active_ff && bit_valid_i && !abort_i;
   wire keep_w = take_w && !stuff_slot_w;
   wire addr_last_w = !data_ph_ff && acnt_ff == 8'(ADDR_W - 1);
   wire addr_ok_w = {addr_ff[ADDR_W-2:0], bit_i} == target_addr_i;
   wire [5:0] nxt_dcnt = dcnt_ff + 6'h1;
   wire fix_end_w = !use_stop_i && nxt_dcnt == {1'b0, payload_length_i} + 6'h1;
   wire ovf_w = use_stop_i && nxt_dcnt == WKM_DATA_MAX + WKM_STOP_TAIL;
   wire [36:0] nxt_sh = {sh_ff[35:0], bit_i};
   wire [5:0] stop_len_w = nxt_dcnt - WKM_STOP_TAIL;
   wire short_stop_w = nxt_dcnt <= WKM_STOP_TAIL;
   wire empty_w = !use_addr_i && !use_data_i;

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         active_ff <= 1'b0;
         data_ph_ff <= 1'b0;
         last_ff <= 1'b0;
         run_ff <= 3'h0;
         acnt_ff <= 8'h00;
         dcnt_ff <= 6'h00;
         addr_ff <= '0;
         sh_ff <= 37'h0;
         done_ff <= 1'b0;
         ok_ff <= 1'b0;
         err_ff <= 1'b0;
         len_ff <= 5'h00;
         pay_ff <= 32'h0;
      end
      else
      begin
         done_ff <= 1'b0;
         if (start_i && empty_w)
         begin
            done_ff <= 1'b1;
            ok_ff <= 1'b1;
            err_ff <= 1'b0;
            len_ff <= 5'h00;
            pay_ff <= 32'h0;
         end
         else if (start_i)
         begin
            active_ff <= 1'b1;
            data_ph_ff <= !use_addr_i;
            run_ff <= 3'h0;
            acnt_ff <= 8'h00;
            dcnt_ff <= 6'h00;
            sh_ff <= 37'h0;
         end
         else if (abort_i)
            active_ff <= 1'b0;
         else if (take_w)
         begin
            last_ff <= bit_i;
            run_ff <= stuff_slot_w && !same_w ? 3'h1 : nxt_run;
            if (stop_w || stuff_err_w)
            begin
               active_ff <= 1'b0;
               done_ff <= 1'b1;
               ok_ff <= stop_w && !short_stop_w;
               err_ff <= stuff_err_w || short_stop_w;
               len_ff <= stop_len_w[4:0] - 5'h1;
               pay_ff <= nxt_sh[36:5];
            end
            else if (keep_w && !data_ph_ff)
            begin
               addr_ff <= {addr_ff[ADDR_W-2:0], bit_i};
               acnt_ff <= acnt_ff + 8'h1;
               if (addr_last_w)
               begin
                  data_ph_ff <= 1'b1;
                  if (!addr_ok_w || !use_data_i)
                  begin
                     active_ff <= 1'b0;
                     done_ff <= 1'b1;
                     ok_ff <= addr_ok_w;
                     err_ff <= !addr_ok_w;
                     len_ff <= 5'h00;
                     pay_ff <= 32'h0;
                  end
               end
            end
            else if (keep_w)
            begin
               sh_ff <= nxt_sh;
               dcnt_ff <= nxt_dcnt;
               if (use_stop_i && !no_stuff_i && nxt_run == WKM_STOP_RUN && bit_i)
                  run_ff <= nxt_run;
               if (fix_end_w || ovf_w || (use_stop_i && no_stuff_i && bit_i
                  && nxt_run == WKM_STOP_RUN))
               begin
                  active_ff <= 1'b0;
                  done_ff <= 1'b1;
                  ok_ff <= fix_end_w || (!ovf_w && !short_stop_w);
                  err_ff <= ovf_w || (!fix_end_w && short_stop_w);
                  len_ff <= fix_end_w ? payload_length_i : stop_len_w[4:0] - 5'h1;
                  pay_ff <= fix_end_w ? nxt_sh[31:0] : nxt_sh[36:5];
               end
            end
         end
      end
   end

   assign done_o = done_ff;
   assign ok_o = ok_ff;
   assign err_o = err_ff;
   assign len_o = len_ff;
   assign payload_o = pay_ff;
endmodule

// *** hdl/wkm_wake_ctrl.sv ***
// Purpose: Wake-up control word and periodic scan sequencer
// Assumes: Scan ticks come from the RC and reference oscillator domains
// Notes: Register port is the parallel side of the serial host link
// How it works
// - Enable bit starts scanning; valid message clears it
// - Bit 30 selects message data field
// - Stop clear means fixed data length
// - Stop set ends data at stop field
// - Length field holds length minus one
// - Bit 23 selects target field, reset one
// - Debug bit enables the status fault flag
// - Scan interval timed by 10 ms ticks
// - Signal-level check delay from 1 ms ticks
// - Check delay counts from oscillator start
// - Header delay is multiple of check delay
// - Bit 2 set disables bit stuffing
// - Control word resets to 7f8be110
// - Status bit 17 mirrors wake alert
// - Status bits 14-10 give stored length
// - Status bit 15 flags faulty message
`timescale 1ns/1ps
module wkm_wake_ctrl
   import wkm_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ctrl_wr_i,
   input wire logic [31:0] ctrl_wdata_i,
   output logic [31:0] ctrl_rdata_o,
   output logic [31:0] status_o,
   output logic [31:0] wake_payload_store_o,
   input wire logic [ADDR_W-1:0] target_addr_i,
   input wire logic rc_tick_i,
   input wire logic ms_tick_i,
   input wire logic osc_ready_i,
   output logic osc_en_o,
   output logic rx_en_o,
   input wire logic signal_level_check_i,
   input wire logic header_found_i,
   input wire logic bit_valid_i,
   input wire logic bit_i,
   output logic wake_alert_o
);
   logic [31:0] ctrl_ff;
   wkm_state_type state_ff, nxt_state;
   logic [15:0] cnt_ff;
   logic [4:0] mult_ff;
   logic wake_ff, fault_ff;
   logic [2:0] rc_sync_ff, ms_sync_ff;
   logic [1:0] rdy_sync_ff;
   logic done_w, ok_w, err_w;
   logic [4:0] rx_len_w;
   logic [4:0] len_ff;
   logic [31:0] pay_w;

   function automatic logic [4:0] hdr_mult(input logic [2:0] code);
      case (code)
         3'h5: hdr_mult = 5'h08;
         3'h6: hdr_mult = 5'h10;
         3'h7: hdr_mult = 5'h1f;
         default: hdr_mult = {2'h0, code};
      endcase
   endfunction

   // Oscillator-domain inputs, two flops; the two ticks then an edge stage
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         rc_sync_ff <= 3'h0;
         ms_sync_ff <= 3'h0;
         rdy_sync_ff <= 2'h0;
      end
      else
      begin
         rc_sync_ff <= {rc_sync_ff[1:0], rc_tick_i};
         ms_sync_ff <= {ms_sync_ff[1:0], ms_tick_i};
         rdy_sync_ff <= {rdy_sync_ff[0], osc_ready_i};
      end
   end

   wire rc_tick_w = rc_sync_ff[1] && !rc_sync_ff[2];
   wire ms_tick_w = ms_sync_ff[1] && !ms_sync_ff[2];
   wire osc_rdy_w = rdy_sync_ff[1];

   wire en_w = ctrl_ff[WKM_EN_BIT];
   wire [8:0] per_w = ctrl_ff[WKM_PER_HI:WKM_PER_LO];
   wire [6:0] rssi_w = ctrl_ff[WKM_RSSI_HI:WKM_RSSI_LO];
   wire [4:0] mult_w = hdr_mult(ctrl_ff[WKM_HDR_HI:WKM_HDR_LO]);
   // Period in 10 ms ticks: prescale times count, plus one
   wire [15:0] per_pre_w = per_w[8:7] == 2'h3 ? WKM_PRE_256
      : per_w[8:7] == 2'h0 ? 16'h0001 : WKM_PRE_16;
   wire [15:0] per_ticks_w = per_w[8:7] == 2'h0 ? {9'h0, per_w[6:0]} + 16'h1
      : 16'(per_pre_w * {9'h0, per_w[6:0]}) + 16'h1;
   // Check delay in 1 ms ticks: prescale times (count plus one)
   wire [15:0] rssi_ticks_w = rssi_w[6] ? {5'h0, {1'b0, rssi_w[5:0]} + 7'h01, 4'h0}
      : {10'h0, rssi_w[5:0]} + 16'h1;
   wire in_tick_w = state_ff == WKM_PERIOD ? rc_tick_w : ms_tick_w;
   wire [15:0] cnt_inc_w = cnt_ff + 16'h1;
   wire per_end_w = state_ff == WKM_PERIOD && rc_tick_w && cnt_inc_w >= per_ticks_w;
   wire dly_state_w = state_ff == WKM_RSSI_WAIT || state_ff == WKM_HDR_WAIT;
   wire dly_end_w = dly_state_w && ms_tick_w && cnt_inc_w >= rssi_ticks_w;
   wire hdr_now_w = state_ff == WKM_RSSI_WAIT && dly_end_w && mult_w == 5'h00;
   wire start_w = (hdr_now_w || (state_ff == WKM_HDR_WAIT && dly_end_w
      && mult_ff == 5'h01)) && signal_level_check_i && header_found_i;
   wire good_w = done_w && ok_w && !(err_w && ctrl_ff[WKM_DBG_BIT]);
   wire abort_w = ctrl_wr_i && !ctrl_wdata_i[WKM_EN_BIT];

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         WKM_OFF:
            if (en_w)
               nxt_state = WKM_PERIOD;
         WKM_PERIOD:
            if (per_end_w)
               nxt_state = WKM_OSC_WAIT;
         WKM_OSC_WAIT:
            if (osc_rdy_w)
               nxt_state = WKM_RSSI_WAIT;
         WKM_RSSI_WAIT:
            if (dly_end_w && !signal_level_check_i)
               nxt_state = WKM_PERIOD;
            else if (start_w)
               nxt_state = WKM_MSG;
            else if (dly_end_w && mult_w == 5'h00)
               nxt_state = WKM_PERIOD;
            else if (dly_end_w)
               nxt_state = WKM_HDR_WAIT;
         WKM_HDR_WAIT:
            if (start_w)
               nxt_state = WKM_MSG;
            else if (dly_end_w && mult_ff == 5'h01)
               nxt_state = WKM_PERIOD;
         WKM_MSG:
            if (good_w)
               nxt_state = WKM_OFF;
            else if (done_w)
               nxt_state = WKM_PERIOD;
         default:
            nxt_state = WKM_OFF;
      endcase
      if (!en_w || abort_w)
         nxt_state = WKM_OFF;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_ff <= WKM_OFF;
         cnt_ff <= 16'h0;
         mult_ff <= 5'h00;
      end
      else
      begin
         state_ff <= nxt_state;
         if (nxt_state != state_ff || dly_end_w)
            cnt_ff <= 16'h0;
         else if (in_tick_w)
            cnt_ff <= cnt_inc_w;
         if (state_ff == WKM_RSSI_WAIT)
            mult_ff <= mult_w;
         else if (state_ff == WKM_HDR_WAIT && dly_end_w)
            mult_ff <= mult_ff - 5'h1;
      end
   end

   // Control word; host write wins over the hardware clear
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         ctrl_ff <= WKM_CTRL_RESET;
      else if (ctrl_wr_i)
         ctrl_ff <= ctrl_wdata_i & ~WKM_CTRL_RSV_MASK;
      else if (state_ff == WKM_MSG && good_w)
         ctrl_ff[WKM_EN_BIT] <= 1'b0;
   end

   // Status flags; a new event wins over the clear by re-enable
   wire rearm_w = ctrl_wr_i && ctrl_wdata_i[WKM_EN_BIT];
   wire wake_set_w = state_ff == WKM_MSG && good_w;
   wire fault_set_w = state_ff == WKM_MSG && done_w && err_w && ctrl_ff[WKM_DBG_BIT];

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wake_ff <= 1'b0;
         fault_ff <= 1'b0;
         len_ff <= 5'h00;
      end
      else
      begin
         wake_ff <= wake_set_w || (wake_ff && !rearm_w);
         fault_ff <= fault_set_w || (fault_ff && !rearm_w);
         if (wake_set_w)
            len_ff <= rx_len_w;
      end
   end

   wkm_msg_rx #(
      .ADDR_W(ADDR_W)
   ) u_msg_rx (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .start_i(start_w),
      .abort_i(nxt_state != WKM_MSG && state_ff == WKM_MSG && !done_w),
      .use_data_i(ctrl_ff[WKM_DATA_BIT]),
      .use_stop_i(ctrl_ff[WKM_STOP_BIT]),
      .use_addr_i(ctrl_ff[WKM_ADDR_BIT]),
      .no_stuff_i(ctrl_ff[WKM_NOSTUFF_BIT]),
      .payload_length_i(ctrl_ff[WKM_LEN_HI:WKM_LEN_LO]),
      .target_addr_i(target_addr_i),
      .bit_valid_i(bit_valid_i),
      .bit_i(bit_i),
      .done_o(done_w),
      .ok_o(ok_w),
      .err_o(err_w),
      .len_o(rx_len_w),
      .payload_o(pay_w)
   );

   logic [31:0] store_ff;
   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         store_ff <= 32'h0;
      else if (wake_set_w)
         store_ff <= pay_w;
   end

   wire [31:0] status_w = (32'(wake_ff) << WKM_ST_WAKE_BIT)
      | (32'(fault_ff) << WKM_ST_FAULT_BIT)
      | (32'(len_ff) << WKM_ST_LEN_LO);

   assign ctrl_rdata_o = ctrl_ff;
   assign status_o = status_w;
   assign wake_payload_store_o = store_ff;
   assign wake_alert_o = wake_ff;
   assign osc_en_o = state_ff != WKM_OFF && state_ff != WKM_PERIOD;
   assign rx_en_o = state_ff == WKM_RSSI_WAIT || state_ff == WKM_HDR_WAIT
      || state_ff == WKM_MSG;
endmodule

// *** shared/wkm_pkg.sv ***
// Purpose: Shared constants for the wake-up message control block
// Assumes: One 32-bit control word and one 32-bit status word
// Notes: Bit positions of both words and the control word reset value live here
package wkm_pkg;
   // Control word layout
   localparam logic [31:0] WKM_CTRL_RESET = 32'h7f8be110;
   localparam logic [31:0] WKM_CTRL_RSV_MASK = 32'h00000003;
   localparam int WKM_EN_BIT = 31;
   localparam int WKM_DATA_BIT = 30;
   localparam int WKM_STOP_BIT = 29;
   localparam int WKM_LEN_HI = 28;
   localparam int WKM_LEN_LO = 24;
   localparam int WKM_ADDR_BIT = 23;
   localparam int WKM_DBG_BIT = 22;
   localparam int WKM_PER_HI = 21;
   localparam int WKM_PER_LO = 13;
   localparam int WKM_RSSI_HI = 12;
   localparam int WKM_RSSI_LO = 6;
   localparam int WKM_HDR_HI = 5;
   localparam int WKM_HDR_LO = 3;
   localparam int WKM_NOSTUFF_BIT = 2;
   // Status word layout
   localparam int WKM_ST_WAKE_BIT = 17;
   localparam int WKM_ST_FAULT_BIT = 15;
   localparam int WKM_ST_LEN_HI = 14;
   localparam int WKM_ST_LEN_LO = 10;
   // Message framing
   localparam logic [2:0] WKM_STUFF_RUN = 3'h5;
   localparam logic [2:0] WKM_STOP_RUN = 3'h6;
   localparam logic [5:0] WKM_DATA_MAX = 6'h20;
   localparam logic [5:0] WKM_STOP_TAIL = 6'h05;
   // Timer prescalers
   localparam logic [15:0] WKM_PRE_16 = 16'h0010;
   localparam logic [15:0] WKM_PRE_256 = 16'h0100;
   typedef enum logic [2:0] {
      WKM_OFF,
      WKM_PERIOD,
      WKM_OSC_WAIT,
      WKM_RSSI_WAIT,
      WKM_HDR_WAIT,
      WKM_MSG
   } wkm_state_type;
endpackage

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the wake-up control block
// Assumes: Ticks and received bits driven here
// Notes: Rssi code 0 and header code 0 used in all tests except t_delay
`timescale 1ns/1ps
module tb_top
   import wkm_pkg::*;
;
   logic clk_i = 0, rst_i = 1, ctrl_wr_i, rc_tick_i = 0, ms_tick_i = 0, osc_ready_i = 0;
   logic osc_en_o, rx_en_o, bit_valid_i = 0, bit_i = 0, wake_alert_o, sig_ok = 1, hdr_ok = 1;
   logic [31:0] ctrl_wdata_i, ctrl_rdata_o, status_o, wake_payload_store_o, c;
   int miscompares = 0, n_compared = 0, cycles = 0;

   wkm_host host (.clk_i(clk_i), .wr_o(ctrl_wr_i), .wdata_o(ctrl_wdata_i));
   wkm_wake_ctrl #(.ADDR_W(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .ctrl_wr_i(ctrl_wr_i),
      .ctrl_wdata_i(ctrl_wdata_i), .ctrl_rdata_o(ctrl_rdata_o), .status_o(status_o),
      .wake_payload_store_o(wake_payload_store_o), .target_addr_i(8'ha5),
      .rc_tick_i(rc_tick_i), .ms_tick_i(ms_tick_i), .osc_ready_i(osc_ready_i),
      .osc_en_o(osc_en_o), .rx_en_o(rx_en_o), .signal_level_check_i(sig_ok),
      .header_found_i(hdr_ok), .bit_valid_i(bit_valid_i), .bit_i(bit_i),
      .wake_alert_o(wake_alert_o));

   initial
   begin
      forever #2 clk_i = ~clk_i;
   end

   // Oscillator comes up 1 ns after the edge that raises the request
   always @(posedge clk_i) #1 osc_ready_i = osc_en_o;

   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         miscompares++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_compared++;
      if (g !== e)
      begin
         miscompares++;
         $display("unexpected at %0t: %s got %h exp %h", $time, m, g, e);
      end
   endtask

   function automatic logic [31:0] cfg(input logic d, input logic s, input logic [4:0] l,
      input logic a, input logic g, input logic [8:0] p, input logic ns);
      return {1'b1, d, s, l, a, g, p, 7'h00, 3'h0, ns, 2'b00};
   endfunction

   task automatic pulse(input bit ms);
      @(posedge clk_i);
      #1 if (ms) ms_tick_i = 1; else rc_tick_i = 1;
      repeat (2) @(posedge clk_i);
      #1 if (ms) ms_tick_i = 0; else rc_tick_i = 0;
      repeat (6) @(posedge clk_i);
   endtask

   // Config, count rc ticks to oscillator, then one ms tick to header check
   task automatic scan(input logic [31:0] v, input int exp_rc);
      int n;
      c = v;
      host.write(v);
      n = 0;
      while (osc_en_o !== 1'b1 && n < 20)
      begin
         pulse(0);
         n++;
      end
      chk(32'(n), 32'(exp_rc), "rc ticks");
      repeat (6) @(posedge clk_i);
      chk({31'h0, rx_en_o}, 32'h1, "receiver on");
      pulse(1);
      repeat (10) @(posedge clk_i);
   endtask

   task automatic send(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--)
      begin
         @(posedge clk_i);
         #1 bit_valid_i = 1;
         bit_i = v[i];
         @(posedge clk_i);
         #1 bit_valid_i = 0;
      end
   endtask

   task automatic woke(input logic [31:0] pay, input logic [4:0] len);
      repeat (5) @(posedge clk_i);
      chk({31'h0, wake_alert_o}, 32'h1, "wake pin");
      chk(ctrl_rdata_o, {1'b0, c[30:0]}, "enable cleared");
      chk(wake_payload_store_o, pay, "payload");
      chk({27'h0, status_o[14:10]}, {27'h0, len}, "stored length");
   endtask

   task automatic t_reset();
      chk(ctrl_rdata_o, 32'h7f8be110, "reset word");
      chk(status_o, 32'h0, "reset status");
   endtask

   task automatic t_empty();
      scan(cfg(0, 0, 5'h00, 0, 0, 9'h000, 1), 1);
      woke(32'h0, 5'h00);
   endtask

   task automatic t_addr();
      scan(cfg(1, 0, 5'h03, 1, 0, 9'h002, 1), 3);
      send(16'h00a5, 8);
      send(16'h000b, 4);
      woke(32'hb, 5'h03);
   endtask

   task automatic t_stuff();
      scan(cfg(1, 0, 5'h07, 0, 0, 9'h000, 0), 1);
      send(16'h01f7, 9);
      woke(32'hff, 5'h07);
   endtask

   task automatic t_stop();
      scan(cfg(1, 1, 5'h1f, 0, 0, 9'h000, 1), 1);
      send(16'h013f, 10);
      woke(32'h9, 5'h04);
   endtask

   // Check delay code 1 is two ticks; header code 2 adds two more delays
   task automatic t_delay();
      int n;
      c = cfg(0, 0, 5'h00, 0, 0, 9'h000, 1) | 32'h00000050;
      host.write(c);
      pulse(0);
      n = 0;
      while (wake_alert_o !== 1'b1 && n < 20)
      begin
         pulse(1);
         n++;
      end
      chk(32'(n), 32'h6, "check delay ticks");
      chk(ctrl_rdata_o, {1'b0, c[30:0]}, "enable cleared");
   endtask

   task automatic t_nodebug();
      scan(cfg(1, 0, 5'h07, 0, 0, 9'h000, 0), 1);
      send(16'h01ff, 9);
      repeat (10) @(posedge clk_i);
      chk({31'h0, status_o[WKM_ST_FAULT_BIT]}, 32'h0, "fault outside debug");
      chk({31'h0, wake_alert_o}, 32'h0, "no wake on stuff error");
   endtask

   task automatic t_fault();
      scan(cfg(1, 0, 5'h07, 0, 1, 9'h000, 0), 1);
      send(16'h01ff, 9);
      repeat (10) @(posedge clk_i);
      chk({31'h0, status_o[WKM_ST_FAULT_BIT]}, 32'h1, "fault flag");
      chk({31'h0, wake_alert_o}, 32'h0, "no wake on fault");
      host.write(32'h0);
      repeat (2) @(posedge clk_i);
      chk({31'h0, osc_en_o}, 32'h0, "abort");
   endtask

   initial
   begin
      repeat (3) @(posedge clk_i);
      #1 rst_i = 0;
      t_reset();
      t_empty();
      t_addr();
      t_stuff();
      t_stop();
      t_delay();
      t_nodebug();
      t_fault();
      give_verdict();
   end
endmodule

// *** verif/wkm_host.sv ***
// Purpose: Host model writing the wake-up control word
// Assumes: Parallel write port, one-cycle strobe
// Notes: Keeps the host-side format rules
`timescale 1ns/1ps
module wkm_host
(
   input wire logic clk_i,
   output logic wr_o,
   output logic [31:0] wdata_o
);
   initial
   begin
      wr_o = 1'b0;
      wdata_o = 32'h00000000;
   end

   task automatic put(input logic [31:0] v);
      @(posedge clk_i);
      #1 wr_o = 1'b1;
      wdata_o = v;
      @(posedge clk_i);
      #1 wr_o = 1'b0;
   endtask

   // Disable first, then load format with enable
   task automatic write(input logic [31:0] v);
      logic [31:0] w;
      w = v & 32'hfffffffc;
      if (w[29])
      begin
         w[28:24] = 5'h1f;
      end
      if (w[31])
      begin
         put({1'b0, w[30:0]});
      end
      put(w);
   endtask
endmodule

// *** verif/wkm_wake_chk.sv ***
// Purpose: Port checker for the wake-up control block
// Assumes: One clock, async reset active high
// Notes: Bound onto the control block
`timescale 1ns/1ps
module wkm_wake_chk
   import wkm_pkg::*;
#(
   parameter int ADDR_W = 8
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ctrl_wr_i,
   input wire logic [31:0] ctrl_wdata_i,
   input wire logic [31:0] ctrl_rdata_o,
   input wire logic [31:0] status_o,
   input wire logic osc_en_o,
   input wire logic rx_en_o,
   input wire logic wake_alert_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   property p_wr_back;
      ctrl_wr_i |=> ctrl_rdata_o == ($past(ctrl_wdata_i) & ~WKM_CTRL_RSV_MASK);
   endproperty
   a_wr_back: assert property (p_wr_back) else $error("readback differs");
   property p_abort;
      ctrl_wr_i && !ctrl_wdata_i[WKM_EN_BIT] |-> ##2 !osc_en_o && !rx_en_o;
   endproperty
   a_abort: assert property (p_abort) else $error("scan not stopped");
   property p_mirror;
      wake_alert_o == status_o[WKM_ST_WAKE_BIT];
   endproperty
   a_mirror: assert property (p_mirror) else $error("wake flag differs from pin");
   property p_wake_clr;
      $rose(wake_alert_o) |-> !ctrl_rdata_o[WKM_EN_BIT] && !osc_en_o && !rx_en_o;
   endproperty
   a_wake_clr: assert property (p_wake_clr) else $error("enable kept after wake");
   property p_rx_osc;
      rx_en_o |-> osc_en_o;
   endproperty
   a_rx_osc: assert property (p_rx_osc) else $error("receiver on without oscillator");
   property p_osc_en;
      $rose(osc_en_o) |-> ctrl_rdata_o[WKM_EN_BIT];
   endproperty
   a_osc_en: assert property (p_osc_en) else $error("oscillator while disabled");
   property p_fault;
      $rose(status_o[WKM_ST_FAULT_BIT]) |-> ctrl_rdata_o[WKM_DBG_BIT] && !wake_alert_o;
   endproperty
   a_fault: assert property (p_fault) else $error("fault outside debug mode");
   property p_len;
      $rose(wake_alert_o) && ctrl_rdata_o[WKM_DATA_BIT] && !ctrl_rdata_o[WKM_STOP_BIT]
         |-> status_o[14:10] == ctrl_rdata_o[28:24];
   endproperty
   a_len: assert property (p_len) else $error("fixed length wrong");
   property p_unused;
      status_o[31:18] == 14'h0000 && !status_o[16] && status_o[9:0] == 10'h000;
   endproperty
   a_unused: assert property (p_unused) else $error("unused status bit set");

   c_wake: cover property ($rose(wake_alert_o));
   c_fault: cover property ($rose(status_o[WKM_ST_FAULT_BIT]));
   c_abort: cover property (ctrl_wr_i && !ctrl_wdata_i[WKM_EN_BIT] && osc_en_o);
endmodule

bind wkm_wake_ctrl wkm_wake_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
   .ctrl_wr_i(ctrl_wr_i), .ctrl_wdata_i(ctrl_wdata_i), .ctrl_rdata_o(ctrl_rdata_o),
   .status_o(status_o), .osc_en_o(osc_en_o), .rx_en_o(rx_en_o),
   .wake_alert_o(wake_alert_o));
